//--- hdl/cae_exec.sv
// Executor for arithmetic, compare/skip and branch instructions
// Operation
// - Short I/O reaches 0x00-0x3F, data address +0x20
// - Bit set/clear/skip only at I/O up to 0x1F
// - I/O bit set/clear touches only that bit
// - Extended I/O only through memory read/write
// - Add and add-carry: sum, ZCNVH, one cycle
// - Word add/minus immediate: ZCNVS, two cycles
// - Minus forms: difference, ZCNVH, one cycle
// - AND/OR/XOR: one cycle, only Z N V
// - Mask clear ANDs inverse, mask set ORs
// - Invert gives FF minus, negate gives 00 minus
// - Count up/down: one cycle, Z N V only
// - Zeroing is XOR with itself, Z N V
// - Compares set flags, store nothing, one cycle
// - Relative jump: PC plus offset plus one, two cycles
// - Indirect jump two cycles, indirect call three
// - Absolute jump three cycles, absolute call four
// - Relative call saves return, three cycles
// - Compare-skip-equal skips two or three, flags kept
// - Register bit skips take one, two or three
// - I/O bit skips take one, two or three
// - Flag branches: one cycle untaken, two taken
module cae_exec
    import cae_pkg::*;
#(
    parameter int PC_W = PC_WIDTH
)
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic start,
    input wire cae_op_t op,
    input wire logic [7:0] rd_val,
    input wire logic [7:0] source_operand,
    input wire logic [15:0] word_val,
    input wire logic [2:0] bit_sel,
    input wire logic [2:0] flag_sel,
    input wire logic signed [11:0] offset,
    input wire logic [PC_W-1:0] abs_target,
    input wire logic [15:0] z_ptr,
    input wire logic two_word,
    input wire logic [7:0] io_addr,
    input wire logic [7:0] io_rdata,
    output logic busy_reg,
    output logic done_reg,
    output logic [PC_W-1:0] pc_reg,
    output logic [7:0] sreg_reg,
    output logic [7:0] res_reg,
    output logic res_we_reg,
    output logic [15:0] word_res_reg,
    output logic word_we_reg,
    output logic push_we_reg,
    output logic [PC_W-1:0] push_addr_reg,
    output cae_mem_t mem_reg,
    output logic err_reg
);

    // Fixed cycle count of an operation
    function automatic logic [2:0] fixed_cycles(cae_op_t o);
        case (o)
            OP_WORD_IMMEDIATE_ADD, OP_WORD_IMMEDIATE_MINUS: return CYC_WORD;
            OP_RELATIVE_JUMP: return CYC_REL_JUMP;
            OP_INDIRECT_JUMP: return CYC_IND_JUMP;
            OP_INDIRECT_CALL: return CYC_IND_CALL;
            OP_ABSOLUTE_JUMP: return CYC_ABS_JUMP;
            OP_ABSOLUTE_CALL: return CYC_ABS_CALL;
            OP_RELATIVE_CALL: return CYC_REL_CALL;
            OP_IO_BIT_SET, OP_IO_BIT_CLEAR: return CYC_IO_BIT;
            OP_MEMORY_READ, OP_MEMORY_WRITE: return CYC_MEMORY;
            default: return CYC_SINGLE;
        endcase
    endfunction

    cae_state_t state_reg;
    cae_state_t state_next;
    logic [1:0] cnt_reg;
    logic [1:0] cnt_next;
    logic var_reg;
    logic take_reg;
    logic take_now;
    logic [PC_W-1:0] pc_next;
    cae_alu_t alu_res;
    cae_mem_t mem_start;

    // Operation classes
    wire is_word = (op == OP_WORD_IMMEDIATE_ADD) ||
        (op == OP_WORD_IMMEDIATE_MINUS);
    wire is_alu = (op <= OP_REGISTER_FILL_ONES);
    wire is_cmp = (op == OP_COMPARE) || (op == OP_COMPARE_WITH_CARRY) ||
        (op == OP_COMPARE_IMMEDIATE);
    wire is_short = (op == OP_IO_READ) || (op == OP_IO_WRITE);
    wire is_iobit = (op == OP_IO_BIT_SET) || (op == OP_IO_BIT_CLEAR);
    wire is_ioskip = (op == OP_SKIP_IO_BIT_CLEAR) ||
        (op == OP_SKIP_IO_BIT_SET);
    wire is_mem = (op == OP_MEMORY_READ) || (op == OP_MEMORY_WRITE);
    wire is_skip = is_ioskip || (op == OP_COMPARE_SKIP_EQUAL) ||
        (op == OP_SKIP_REG_BIT_CLEAR) || (op == OP_SKIP_REG_BIT_SET);
    wire is_branch = (op == OP_BRANCH_FLAG_SET) ||
        (op == OP_BRANCH_FLAG_CLEAR) || (op == OP_BRANCH_IF_EQUAL) ||
        (op == OP_BRANCH_IF_UNEQUAL);
    wire is_call = (op == OP_RELATIVE_CALL) || (op == OP_INDIRECT_CALL) ||
        (op == OP_ABSOLUTE_CALL);
    wire is_read = (op == OP_IO_READ) || (op == OP_MEMORY_READ);
    wire is_write = (op == OP_IO_WRITE) || (op == OP_MEMORY_WRITE);
    wire io_any = is_mem || is_short || is_iobit || is_ioskip;
    wire alu_store = is_alu && !is_word && !is_cmp &&
        (op != OP_ZERO_SIGN_CHECK);

    // Address checks: short forms reach 64 places, bit forms the low 32
    wire short_ok = (io_addr <= IO_LAST);
    wire bit_ok = (io_addr <= IO_BIT_LAST);
    wire io_ok = is_mem || (is_short && short_ok) ||
        ((is_iobit || is_ioskip) && bit_ok);
    wire [7:0] data_addr = is_mem ? io_addr : io_addr + IO_DATA_OFS;
    wire [7:0] bit_mask = 8'h01 << bit_sel;

    // Access request; bit forms write a one-bit mask, never the whole byte
    assign mem_start.addr = data_addr;
    assign mem_start.wdata = is_iobit ?
        ((op == OP_IO_BIT_SET) ? 8'hFF : 8'h00) : source_operand;
    assign mem_start.wmask = is_iobit ? bit_mask : 8'hFF;
    assign mem_start.we = io_ok && (is_write || is_iobit);
    assign mem_start.re = io_ok && (is_read || is_ioskip);

    // Arithmetic unit
    cae_alu u_alu (
        .op(op),
        .a(rd_val),
        .b(source_operand),
        .w(word_val),
        .c_in(sreg_reg[FLG_C]),
        .alu_out(alu_res)
    );

    // Skip and branch conditions
    wire flag_hit = sreg_reg[flag_sel];
    wire reg_bit = source_operand[bit_sel];
    wire io_bit = io_rdata[bit_sel];
    always_comb begin
        case (op)
            OP_BRANCH_FLAG_SET: take_now = flag_hit;
            OP_BRANCH_FLAG_CLEAR: take_now = !flag_hit;
            OP_BRANCH_IF_EQUAL: take_now = sreg_reg[FLG_Z];
            OP_BRANCH_IF_UNEQUAL: take_now = !sreg_reg[FLG_Z];
            OP_COMPARE_SKIP_EQUAL: take_now = (rd_val == source_operand);
            OP_SKIP_REG_BIT_CLEAR: take_now = !reg_bit;
            OP_SKIP_REG_BIT_SET: take_now = reg_bit;
            OP_SKIP_IO_BIT_CLEAR: take_now = io_ok && !io_bit;
            OP_SKIP_IO_BIT_SET: take_now = io_ok && io_bit;
            default: take_now = 1'b0;
        endcase
    end

    // Sequencing: fixed ops count down, skips and branches decide first
    wire in_exec = (state_reg == ST_EXEC);
    wire accept = (state_reg == ST_IDLE) && start;
    wire decide = in_exec && var_reg;
    wire extend = decide && take_now;
    wire finish = in_exec && (cnt_reg == 2'h0) && !extend;
    wire [1:0] extra_m1 = (is_skip && two_word) ? 2'h1 : 2'h0;
    wire [2:0] fixed_m1 = fixed_cycles(op) - 3'h1;
    assign cnt_next = accept ? ((is_skip || is_branch) ? 2'h0 :
        fixed_m1[1:0]) : (extend ? extra_m1 :
        (in_exec ? cnt_reg - 2'h1 : cnt_reg));
    assign state_next = accept ? ST_EXEC : (finish ? ST_IDLE : state_reg);

    // Program counter targets
    wire [PC_W-1:0] pc_inc1 = pc_reg + PC_W'(1);
    wire [PC_W-1:0] pc_inc2 = pc_reg + PC_W'(2);
    wire [PC_W-1:0] pc_rel = pc_reg + PC_W'(offset) + PC_W'(1);
    wire [PC_W-1:0] pc_skip = two_word ? pc_reg + PC_W'(3) : pc_inc2;
    always_comb begin
        case (op)
            OP_RELATIVE_JUMP, OP_RELATIVE_CALL: pc_next = pc_rel;
            OP_INDIRECT_JUMP, OP_INDIRECT_CALL:
                pc_next = z_ptr[PC_W-1:0];
            OP_ABSOLUTE_JUMP, OP_ABSOLUTE_CALL: pc_next = abs_target;
            default: begin
                if (is_skip && take_reg) begin
                    pc_next = pc_skip;
                end else if (is_branch && take_reg) begin
                    pc_next = pc_rel;
                end else begin
                    pc_next = pc_inc1;
                end
            end
        endcase
    end

    // New status: only the flags that the operation owns change
    wire [7:0] sreg_next = (sreg_reg & ~alu_res.upd) |
        (alu_res.flags & alu_res.upd);
    wire [PC_W-1:0] ret_addr = (op == OP_ABSOLUTE_CALL) ? pc_inc2 : pc_inc1;

    // Sequencer state
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_reg <= ST_IDLE;
            cnt_reg <= 2'h0;
            var_reg <= 1'b0;
            take_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            var_reg <= accept ? (is_skip || is_branch) : (var_reg && !decide);
            take_reg <= accept ? 1'b0 : (extend ? 1'b1 : take_reg);
        end
    end

    // Commit of results at the last cycle
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
            pc_reg <= PC_W'(PC_RESET);
            sreg_reg <= SREG_RESET;
            res_reg <= 8'h00;
            res_we_reg <= 1'b0;
            word_res_reg <= 16'h0000;
            word_we_reg <= 1'b0;
            push_we_reg <= 1'b0;
            push_addr_reg <= '0;
            err_reg <= 1'b0;
        end else begin
            busy_reg <= accept || (busy_reg && !finish);
            done_reg <= finish;
            pc_reg <= finish ? pc_next : pc_reg;
            sreg_reg <= (finish && is_alu) ? sreg_next : sreg_reg;
            res_reg <= !finish ? res_reg : (is_alu ? alu_res.res : io_rdata);
            res_we_reg <= finish && (alu_store || (is_read && io_ok));
            word_res_reg <= finish ? alu_res.wres : word_res_reg;
            word_we_reg <= finish && is_word;
            push_we_reg <= finish && is_call;
            push_addr_reg <= finish ? ret_addr : push_addr_reg;
            err_reg <= finish && io_any && !io_ok;
        end
    end

    // Data-space request stands from acceptance to the last cycle
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            mem_reg <= '0;
        end else if (accept) begin
            mem_reg <= mem_start;
        end else if (finish) begin
            mem_reg <= '0;
        end
    end

    // Checks on the executor
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    a_io_short_map: assert property ($rose(busy_reg) && op == OP_IO_READ
        && io_addr <= IO_LAST |-> mem_reg.re &&
        mem_reg.addr == 8'(io_addr + IO_DATA_OFS))
        else $error("short read not mapped with offset");
    a_io_bit_range: assert property (mem_reg.we && is_iobit
        |-> io_addr <= IO_BIT_LAST)
        else $error("bit write above bit-accessible range");
    a_bit_mask_single: assert property (mem_reg.we && is_iobit
        |-> $onehot(mem_reg.wmask) && mem_reg.wmask == bit_mask)
        else $error("bit write touches more than one bit");
    a_ext_mem_only: assert property ((mem_reg.we || mem_reg.re) &&
        mem_reg.addr >= EXT_FIRST |-> is_mem)
        else $error("extended space reached by short form");
    a_add_one_cycle: assert property ($rose(busy_reg) && op == OP_ADD
        |=> done_reg && res_we_reg &&
        res_reg == 8'($past(rd_val) + $past(source_operand)))
        else $error("add result or timing wrong");
    a_word_two_cycles: assert property ($rose(busy_reg) && is_word
        |=> !done_reg ##1 (done_reg && word_we_reg))
        else $error("word operation not two cycles");
    a_minus_one_cycle: assert property ($rose(busy_reg) && op == OP_MINUS
        |=> done_reg &&
        res_reg == 8'($past(rd_val) - $past(source_operand)))
        else $error("minus result or timing wrong");
    a_logic_keeps_carry: assert property (done_reg &&
        ($past(op) == OP_AND || $past(op) == OP_OR ||
        $past(op) == OP_EXCLUSIVE_DISJUNCTION ||
        $past(op) == OP_REGISTER_ZEROING) |->
        sreg_reg[FLG_C] == $past(sreg_reg[FLG_C]) &&
        sreg_reg[FLG_H] == $past(sreg_reg[FLG_H]))
        else $error("logic op changed carry or half carry");
    a_count_keeps_carry: assert property (done_reg &&
        ($past(op) == OP_COUNT_UP || $past(op) == OP_COUNT_DOWN) |->
        sreg_reg[FLG_C] == $past(sreg_reg[FLG_C]))
        else $error("count op changed carry");
    a_compare_no_store: assert property (done_reg && $past(is_cmp)
        |-> !res_we_reg)
        else $error("compare stored a result");
    a_rel_jump_target: assert property ($rose(busy_reg) &&
        op == OP_RELATIVE_JUMP |=> !done_reg ##1 (done_reg &&
        pc_reg == PC_W'($past(pc_reg, 2) + PC_W'($past(offset)) +
        PC_W'(1))))
        else $error("relative jump target or timing wrong");
    a_ind_call_three: assert property ($rose(busy_reg) &&
        op == OP_INDIRECT_CALL |-> ##3 (done_reg && push_we_reg &&
        pc_reg == $past(z_ptr[PC_W-1:0])))
        else $error("indirect call not three cycles");
    a_abs_call_four: assert property ($rose(busy_reg) &&
        op == OP_ABSOLUTE_CALL |-> !done_reg [*4] ##1 (done_reg &&
        push_we_reg && pc_reg == $past(abs_target)))
        else $error("absolute call not four cycles");
    a_skip_keeps_flags: assert property (done_reg && $past(is_skip)
        |-> sreg_reg == $past(sreg_reg))
        else $error("skip changed a flag");
    a_branch_not_taken: assert property ($rose(busy_reg) &&
        op == OP_BRANCH_IF_UNEQUAL && sreg_reg[FLG_Z] |=> done_reg &&
        pc_reg == PC_W'($past(pc_reg) + PC_W'(1)))
        else $error("untaken branch not one cycle");

    c_add_done: cover property ($rose(busy_reg) && op == OP_ADD ##1 done_reg);
    c_branch_taken: cover property (done_reg && take_reg && is_branch);
    c_skip_long: cover property (done_reg && take_reg && is_skip && two_word);
    c_call_push: cover property (push_we_reg && op == OP_ABSOLUTE_CALL);

endmodule // cae_exec

//--- pkg/cae_pkg.sv
// Shared constants and types for the arithmetic, skip and branch executor
package cae_pkg;

    // Program counter width in instruction words
    localparam int PC_WIDTH = 13;
    localparam logic [12:0] PC_RESET = 13'h0000;
    localparam logic [7:0] SREG_RESET = 8'h00;

    // I/O space limits and data-space offset
    localparam logic [7:0] IO_LAST = 8'h3F;
    localparam logic [7:0] IO_BIT_LAST = 8'h1F;
    localparam logic [7:0] IO_DATA_OFS = 8'h20;
    localparam logic [7:0] EXT_FIRST = 8'h60;

    // Status flag positions
    localparam int FLG_C = 0;
    localparam int FLG_Z = 1;
    localparam int FLG_N = 2;
    localparam int FLG_V = 3;
    localparam int FLG_S = 4;
    localparam int FLG_H = 5;

    // Flag update masks
    localparam logic [7:0] UPD_ARITH = 8'h2F;
    localparam logic [7:0] UPD_LOGIC = 8'h0E;
    localparam logic [7:0] UPD_INVERT = 8'h0F;
    localparam logic [7:0] UPD_WORD = 8'h1F;
    localparam logic [7:0] UPD_NONE = 8'h00;

    // Cycle counts
    localparam logic [2:0] CYC_SINGLE = 3'h1;
    localparam logic [2:0] CYC_WORD = 3'h2;
    localparam logic [2:0] CYC_REL_JUMP = 3'h2;
    localparam logic [2:0] CYC_IND_JUMP = 3'h2;
    localparam logic [2:0] CYC_IND_CALL = 3'h3;
    localparam logic [2:0] CYC_ABS_JUMP = 3'h3;
    localparam logic [2:0] CYC_ABS_CALL = 3'h4;
    localparam logic [2:0] CYC_REL_CALL = 3'h3;
    localparam logic [2:0] CYC_IO_BIT = 3'h2;
    localparam logic [2:0] CYC_MEMORY = 3'h2;

    // Operations; the first block up to fill ones uses the arithmetic unit
    typedef enum logic [5:0] {
        OP_ADD, OP_ADD_CARRY, OP_WORD_IMMEDIATE_ADD, OP_MINUS,
        OP_MINUS_IMMEDIATE, OP_MINUS_WITH_BORROW,
        OP_MINUS_BORROW_IMMEDIATE, OP_WORD_IMMEDIATE_MINUS, OP_AND,
        OP_CONJUNCTION_IMMEDIATE, OP_OR, OP_DISJUNCTION_IMMEDIATE,
        OP_EXCLUSIVE_DISJUNCTION, OP_BITWISE_INVERT, OP_ARITHMETIC_INVERT,
        OP_BIT_MASK_SET, OP_BIT_MASK_CLEAR, OP_COUNT_UP, OP_COUNT_DOWN,
        OP_ZERO_SIGN_CHECK, OP_REGISTER_ZEROING, OP_COMPARE,
        OP_COMPARE_WITH_CARRY, OP_COMPARE_IMMEDIATE, OP_REGISTER_FILL_ONES,
        OP_RELATIVE_JUMP, OP_INDIRECT_JUMP, OP_ABSOLUTE_JUMP,
        OP_RELATIVE_CALL, OP_INDIRECT_CALL, OP_ABSOLUTE_CALL,
        OP_COMPARE_SKIP_EQUAL, OP_SKIP_REG_BIT_CLEAR, OP_SKIP_REG_BIT_SET,
        OP_SKIP_IO_BIT_CLEAR, OP_SKIP_IO_BIT_SET, OP_BRANCH_FLAG_SET,
        OP_BRANCH_FLAG_CLEAR, OP_BRANCH_IF_EQUAL, OP_BRANCH_IF_UNEQUAL,
        OP_IO_BIT_SET, OP_IO_BIT_CLEAR, OP_IO_READ, OP_IO_WRITE,
        OP_MEMORY_READ, OP_MEMORY_WRITE
    } cae_op_t;

    // Executor states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_EXEC = 2'b10
    } cae_state_t;

    // Data-space access request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic [7:0] wmask;
        logic we;
        logic re;
    } cae_mem_t;

    // Arithmetic unit answer
    typedef struct packed {
        logic [7:0] res;
        logic [15:0] wres;
        logic [7:0] flags;
        logic [7:0] upd;
    } cae_alu_t;

endpackage

//--- hdl/cae_alu.sv
// Combinational arithmetic and logic unit with flag generation
module cae_alu
    import cae_pkg::*;
(
    input wire cae_op_t op,
    input wire logic [7:0] a,
    input wire logic [7:0] b,
    input wire logic [15:0] w,
    input wire logic c_in,
    output cae_alu_t alu_out
);

    // Packs the result-derived and computed flags
    function automatic logic [7:0] pack_flags(logic [7:0] r, logic v,
                                              logic c, logic h);
        logic [7:0] f;
        f = 8'h00;
        f[FLG_Z] = (r == 8'h00);
        f[FLG_N] = r[7];
        f[FLG_V] = v;
        f[FLG_C] = c;
        f[FLG_H] = h;
        return f;
    endfunction

    logic [7:0] x;
    logic [7:0] y;
    logic ci;
    logic [8:0] sum9;
    logic [8:0] dif9;
    logic [4:0] sumh;
    logic [4:0] difh;
    logic [16:0] w17;
    logic vadd;
    logic vsub;
    logic vword;
    wire neg_op = (op == OP_ARITHMETIC_INVERT);
    wire one_op = (op == OP_COUNT_UP) || (op == OP_COUNT_DOWN);
    wire cy_op = (op == OP_ADD_CARRY) || (op == OP_MINUS_WITH_BORROW) ||
        (op == OP_MINUS_BORROW_IMMEDIATE) || (op == OP_COMPARE_WITH_CARRY);
    wire wadd = (op == OP_WORD_IMMEDIATE_ADD);

    // Operand selection, negate is zero minus the register
    assign x = neg_op ? 8'h00 : a;
    assign y = neg_op ? a : (one_op ? 8'h01 : b);
    assign ci = cy_op & c_in;
    assign sum9 = {1'b0, x} + {1'b0, y} + {8'h00, ci};
    assign dif9 = {1'b0, x} - {1'b0, y} - {8'h00, ci};
    assign sumh = {1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, ci};
    assign difh = {1'b0, x[3:0]} - {1'b0, y[3:0]} - {4'h0, ci};
    assign vadd = (x[7] ~^ y[7]) & (x[7] ^ sum9[7]);
    assign vsub = (x[7] ^ y[7]) & (x[7] ^ dif9[7]);

    // Word arithmetic on a register pair with a six-bit constant
    assign w17 = wadd ? ({1'b0, w} + {11'h000, b[5:0]}) :
        ({1'b0, w} - {11'h000, b[5:0]});
    assign vword = wadd ? (~w[15] & w17[15]) : (w[15] & ~w17[15]);

    // Result and flag selection
    always_comb begin
        alu_out.res = a;
        alu_out.wres = w17[15:0];
        alu_out.flags = 8'h00;
        alu_out.upd = UPD_NONE;
        case (op)
            OP_ADD, OP_ADD_CARRY: begin
                alu_out.res = sum9[7:0];
                alu_out.flags = pack_flags(sum9[7:0], vadd, sum9[8], sumh[4]);
                alu_out.upd = UPD_ARITH;
            end
            OP_MINUS, OP_MINUS_IMMEDIATE, OP_MINUS_WITH_BORROW,
            OP_MINUS_BORROW_IMMEDIATE, OP_ARITHMETIC_INVERT, OP_COMPARE,
            OP_COMPARE_WITH_CARRY, OP_COMPARE_IMMEDIATE: begin
                alu_out.res = dif9[7:0];
                alu_out.flags = pack_flags(dif9[7:0], vsub, dif9[8], difh[4]);
                alu_out.upd = UPD_ARITH;
            end
            OP_COUNT_UP: begin
                alu_out.res = sum9[7:0];
                alu_out.flags = pack_flags(sum9[7:0], vadd, 1'b0, 1'b0);
                alu_out.upd = UPD_LOGIC;
            end
            OP_COUNT_DOWN: begin
                alu_out.res = dif9[7:0];
                alu_out.flags = pack_flags(dif9[7:0], vsub, 1'b0, 1'b0);
                alu_out.upd = UPD_LOGIC;
            end
            OP_AND, OP_CONJUNCTION_IMMEDIATE, OP_OR,
            OP_DISJUNCTION_IMMEDIATE, OP_EXCLUSIVE_DISJUNCTION,
            OP_BIT_MASK_SET, OP_BIT_MASK_CLEAR, OP_ZERO_SIGN_CHECK,
            OP_REGISTER_ZEROING: begin
                if (op == OP_AND || op == OP_CONJUNCTION_IMMEDIATE) begin
                    alu_out.res = a & b;
                end else if (op == OP_BIT_MASK_CLEAR) begin
                    alu_out.res = a & ~b;
                end else if (op == OP_EXCLUSIVE_DISJUNCTION) begin
                    alu_out.res = a ^ b;
                end else if (op == OP_REGISTER_ZEROING) begin
                    alu_out.res = a ^ a;
                end else if (op == OP_ZERO_SIGN_CHECK) begin
                    alu_out.res = a & a;
                end else begin
                    alu_out.res = a | b;
                end
                alu_out.flags = pack_flags(alu_out.res, 1'b0, 1'b0, 1'b0);
                alu_out.upd = UPD_LOGIC;
            end
            OP_BITWISE_INVERT: begin
                alu_out.res = 8'hFF - a;
                alu_out.flags = pack_flags(alu_out.res, 1'b0, 1'b1, 1'b0);
                alu_out.upd = UPD_INVERT;
            end
            OP_REGISTER_FILL_ONES: begin
                alu_out.res = 8'hFF;
            end
            OP_WORD_IMMEDIATE_ADD, OP_WORD_IMMEDIATE_MINUS: begin
                alu_out.flags[FLG_Z] = (w17[15:0] == 16'h0000);
                alu_out.flags[FLG_N] = w17[15];
                alu_out.flags[FLG_V] = vword;
                alu_out.flags[FLG_C] = w17[16];
                alu_out.flags[FLG_S] = w17[15] ^ vword;
                alu_out.upd = UPD_WORD;
            end
            default: begin
                alu_out.upd = UPD_NONE;
            end
        endcase
    end

endmodule // cae_alu

//--- verification/cae_mem_model.sv
// Data-space memory model behind the executor
module cae_mem_model
    import cae_pkg::*;
(
    input wire logic clk,
    input wire cae_mem_t mem_reg,
    output logic [7:0] io_rdata
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] mem [256] = '{default: 8'h00};
    // Reads follow the address, writes change masked bits only
    assign io_rdata = mem[mem_reg.addr];
    always @(posedge clk) begin
        if (mem_reg.we) begin
            mem[mem_reg.addr] <= (mem[mem_reg.addr] & ~mem_reg.wmask)
                | (mem_reg.wdata & mem_reg.wmask);
        end
    end
endmodule // cae_mem_model

//--- verification/testbench.sv
// Directed bench for the arithmetic, skip and branch executor
module testbench;
    import cae_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
`define CK(g, e) begin checked++; if ((g) !== (e)) begin fails++; \
$display("Error t=%0t got %h exp %h", $time, g, e); end end
    logic clk = 0, sys_rst = 1, start = 0, two_word = 0;
    logic busy_reg, done_reg, res_we_reg, word_we_reg, push_we_reg, err_reg;
    cae_op_t op = OP_ADD;
    logic [7:0] rd_val = 0, source_operand = 0, io_addr = 0, io_rdata;
    logic [7:0] sreg_reg, res_reg;
    logic [15:0] word_val = 0, z_ptr = 0, word_res_reg;
    logic [2:0] bit_sel = 0, flag_sel = 0;
    logic signed [11:0] offset = 0;
    logic [12:0] abs_target = 0, pc_reg, push_addr_reg;
    cae_mem_t mem_reg;
    int fails = 0, checked = 0, cyc = 0, n;
    cae_exec i_cae_exec (.clk, .sys_rst, .start, .op, .rd_val,
        .source_operand, .word_val, .bit_sel, .flag_sel, .offset,
        .abs_target, .z_ptr, .two_word, .io_addr, .io_rdata, .busy_reg,
        .done_reg, .pc_reg, .sreg_reg, .res_reg, .res_we_reg, .word_res_reg,
        .word_we_reg, .push_we_reg, .push_addr_reg, .mem_reg, .err_reg);
    cae_mem_model i_cae_mem_model (.clk, .mem_reg, .io_rdata);
    // Clock and hang ceiling
    initial begin
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 2000) begin
            fails++;
            wrap_up;
        end
    end
    task automatic wrap_up;
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // Issue one instruction, count cycles up to done
    task automatic go(cae_op_t o, logic [7:0] a, logic [7:0] b, int e);
        op = o;
        rd_val = a;
        source_operand = b;
        start = 1;
        @(posedge clk);
        #1 start = 0;
        n = 0;
        do begin
            @(posedge clk);
            #1 n++;
        end while (done_reg !== 1'b1 && n < 8);
        if (e > 0) `CK(n, e)
        $display("test op %0d ends", o);
    endtask
    task automatic alu(cae_op_t o, logic [7:0] a, b, r, s);
        go(o, a, b, 1);
        `CK(res_reg, r)
        `CK(sreg_reg, s)
    endtask
    // Instruction sequence
    initial begin
        repeat (20) @(posedge clk);
        #1 sys_rst = 0;
        `CK(pc_reg, PC_RESET)
        alu(OP_ADD, 8'hFF, 8'h01, 8'h00, 8'h23);
        alu(OP_ADD_CARRY, 8'h01, 8'h01, 8'h03, 8'h00);
        alu(OP_MINUS, 8'h00, 8'h01, 8'hFF, 8'h25);
        alu(OP_AND, 8'hF0, 8'h0F, 8'h00, 8'h23);
        alu(OP_BIT_MASK_CLEAR, 8'hFF, 8'h0F, 8'hF0, 8'h25);
        alu(OP_COUNT_UP, 8'h7F, 8'h00, 8'h80, 8'h2D);
        go(OP_COMPARE, 8'h05, 8'h05, 1);
        `CK({res_we_reg, sreg_reg}, 9'h002)
        word_val = 16'hFFFF;
        go(OP_WORD_IMMEDIATE_ADD, 8'h00, 8'h01, 2);
        `CK({word_res_reg, sreg_reg}, 24'h000003)
        abs_target = 13'h0100;
        go(OP_ABSOLUTE_JUMP, 8'h00, 8'h00, 3);
        offset = -12'sd3;
        go(OP_BRANCH_IF_EQUAL, 8'h00, 8'h00, 2);
        `CK(pc_reg, 13'h00FE)
        go(OP_BRANCH_IF_UNEQUAL, 8'h00, 8'h00, 1);
        abs_target = 13'h0200;
        go(OP_ABSOLUTE_CALL, 8'h00, 8'h00, 4);
        `CK({push_addr_reg, pc_reg}, 26'h0202200)
        two_word = 1;
        go(OP_COMPARE_SKIP_EQUAL, 8'h33, 8'h33, 3);
        go(OP_COMPARE_SKIP_EQUAL, 8'h33, 8'h34, 1);
        `CK({pc_reg, sreg_reg}, 21'h020403)
        i_cae_mem_model.mem[8'h3C] = 8'h03;
        io_addr = 8'h1C;
        bit_sel = 3'h7;
        go(OP_IO_BIT_SET, 8'h00, 8'h00, 2);
        `CK(i_cae_mem_model.mem[8'h3C], 8'h83)
        two_word = 0;
        go(OP_SKIP_IO_BIT_SET, 8'h00, 8'h00, 2);
        `CK(pc_reg, 13'h0207)
        io_addr = 8'h20;
        go(OP_IO_BIT_SET, 8'h00, 8'h00, 0);
        `CK(err_reg, 1'b1)
        io_addr = 8'h05;
        go(OP_IO_WRITE, 8'hA5, 8'hA5, 1);
        `CK(i_cae_mem_model.mem[8'h25], 8'hA5)
        go(OP_IO_READ, 8'h00, 8'h00, 1);
        `CK({res_we_reg, res_reg}, 9'h1A5)
        io_addr = 8'h60;
        go(OP_MEMORY_WRITE, 8'h5A, 8'h5A, 2);
        `CK(i_cae_mem_model.mem[8'h60], 8'h5A)
        alu(OP_BITWISE_INVERT, 8'h0F, 8'h00, 8'hF0, 8'h05);
        alu(OP_ARITHMETIC_INVERT, 8'h01, 8'h00, 8'hFF, 8'h25);
        alu(OP_REGISTER_ZEROING, 8'h5A, 8'h5A, 8'h00, 8'h23);
        offset = 12'sd16;
        go(OP_RELATIVE_JUMP, 8'h00, 8'h00, 2);
        `CK(pc_reg, 13'h021F)
        z_ptr = 16'h0040;
        go(OP_INDIRECT_CALL, 8'h00, 8'h00, 3);
        `CK({push_addr_reg, pc_reg}, 26'h0440040)
        offset = -12'sd8;
        go(OP_RELATIVE_CALL, 8'h00, 8'h00, 3);
        `CK({push_we_reg, push_addr_reg, pc_reg}, 27'h4082039)
        go(OP_SKIP_REG_BIT_CLEAR, 8'h00, 8'h7F, 2);
        `CK(pc_reg, 13'h003B)
        wrap_up;
    end
endmodule // testbench
